// *** design/fcc_charger.sv ***
// Flyback photoflash charger control logic with a classic Wishbone register slave.
// Assumes analog comparators on the sense inputs and a host driving charge_req_i.
//
// The register addresses and the Wishbone interface to the registers are this design's own decisions.

// Behaviour
// R1: A run starts only on a rising charge request with supply above lockout.
// R2: Request already high when supply recovers does not charge; fresh rise needed.
// R3: Switch turns off as soon as the primary current limit is reported.
// R4: Output feedback is sampled only while the power switch is off.
// R5: At target voltage the run ends and stays idle until request retoggles.
// R6: Fast mode: switch node below threshold turns the switch back on.
// R7: Timer mode: off-interval is limited to 18 us, then switch turns on.
// R8: Timer mode at low output, hand over to fast mode as output rises.
// R9: Strap picks 1.0 A grounded, 1.2 A floating, 1.4 A pulled up.
// R10: Limit changes during a run apply to following cycles without stopping.
// R11: Completion indicator is driven low when the target is reached.
// R12: Request low stops charging and holds the controller in standby.
// R13: Comparator inputs pass a two-stage synchroniser before use.
// R14: Reset holds switch off, completion released, waiting idle.
module fcc_charger (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Host and comparators
    input wire logic charge_req_i,
    input wire logic [1:0] current_limit_strap_i,
    input wire logic current_limit_hit_i,
    input wire logic switch_node_low_i,
    input wire logic voltage_sense_input_i,
    input wire logic supply_lockout_ok_i,
    // Power stage and indicators
    output logic switch_on_o,
    output logic [1:0] peak_current_limit_o,
    output logic done_n_o,
    output logic done_oe_o,
    output logic irq_o
);
    // ----------------------------------------------------------------
    // Input synchronisers and edge detect
    // ----------------------------------------------------------------
    logic current_limit_strap_s, swlow_s, fb_s, supply_s;
    logic req_prev_q, req_rise_w, start_w;
    logic enable_q;
    fcc_pkg::fcc_state_t state_q, state_d;

    fcc_sync #(.W(4)) u_sync ( // [R13]
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i({current_limit_hit_i, switch_node_low_i, voltage_sense_input_i, supply_lockout_ok_i}),
        .q_o({current_limit_strap_s, swlow_s, fb_s, supply_s})
    );

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            req_prev_q <= 1'b1;
        end else begin
            req_prev_q <= charge_req_i;
        end
    end

    assign req_rise_w = charge_req_i && !req_prev_q;
    assign start_w = req_rise_w && supply_s && enable_q; // [R1] [R2]

    // ----------------------------------------------------------------
    // Interval timing
    // ----------------------------------------------------------------
    logic tick_w, tmr_clr_w;
    logic [4:0] us_cnt_q;
    logic [1:0] blank_q;
    logic blank_ok_w, off_exp_w, on_exp_w;

    assign tmr_clr_w = (state_q != state_d);

    fcc_tick #(.DIV(fcc_pkg::CYC_PER_US)) u_tick (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .clr_i(tmr_clr_w),
        .tick_o(tick_w)
    );

    always_ff @(posedge clk_i) begin
        if (rst_i || tmr_clr_w) begin
            us_cnt_q <= 5'h00;
            blank_q <= 2'h0;
        end else begin
            if (tick_w) begin
                us_cnt_q <= us_cnt_q + 5'h01;
            end
            if (!blank_ok_w) begin
                blank_q <= blank_q + 2'h1;
            end
        end
    end

    assign blank_ok_w = (blank_q == 2'(fcc_pkg::MIN_OFF_CYC - 1));
    assign off_exp_w = tick_w && (us_cnt_q == 5'(fcc_pkg::OFF_MAX_US - 1)); // [R7]
    assign on_exp_w = tick_w && (us_cnt_q == 5'(fcc_pkg::ON_MAX_US - 1));

    // ----------------------------------------------------------------
    // Run state machine
    // ----------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        if (!charge_req_i || !supply_s) begin
            state_d = fcc_pkg::FCC_IDLE; // [R12]
        end else begin
            unique case (state_q)
                fcc_pkg::FCC_IDLE, fcc_pkg::FCC_DONE: begin
                    if (start_w) begin
                        state_d = fcc_pkg::FCC_ON; // [R1] [R5]
                    end
                end
                fcc_pkg::FCC_ON: begin
                    if (current_limit_strap_s || on_exp_w) begin
                        state_d = fcc_pkg::FCC_OFF; // [R3]
                    end
                end
                fcc_pkg::FCC_OFF: begin
                    if (blank_ok_w && fb_s) begin
                        state_d = fcc_pkg::FCC_DONE; // [R4] [R5]
                    end else if ((blank_ok_w && swlow_s) || off_exp_w) begin
                        state_d = fcc_pkg::FCC_ON; // [R6] [R7]
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= fcc_pkg::FCC_IDLE; // [R14]
        end else begin
            state_q <= state_d;
        end
    end

    // Mode flag: timer mode from run start, fast once the node rings low
    logic fast_q;
    always_ff @(posedge clk_i) begin
        if (rst_i || start_w) begin
            fast_q <= 1'b0;
        end else if (state_q == fcc_pkg::FCC_OFF && state_d == fcc_pkg::FCC_ON && swlow_s && blank_ok_w) begin
            fast_q <= 1'b1; // [R8]
        end
    end

    // ----------------------------------------------------------------
    // Outputs to the power stage
    // ----------------------------------------------------------------
    logic [1:0] lim_w;
    always_comb begin
        unique case (current_limit_strap_i)
            fcc_pkg::STRAP_GND: lim_w = fcc_pkg::LIM_1A0;
            fcc_pkg::STRAP_SUPPLY: lim_w = fcc_pkg::LIM_1A4;
            default: lim_w = fcc_pkg::LIM_1A2;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            switch_on_o <= 1'b0; // [R14]
            peak_current_limit_o <= fcc_pkg::LIM_1A2;
            done_oe_o <= 1'b0;
        end else begin
            switch_on_o <= (state_d == fcc_pkg::FCC_ON); // [R3]
            if (state_d == fcc_pkg::FCC_ON && state_q != fcc_pkg::FCC_ON) begin
                peak_current_limit_o <= lim_w; // [R9] [R10]
            end
            done_oe_o <= (state_d == fcc_pkg::FCC_DONE); // [R11]
        end
    end

    assign done_n_o = 1'b0;

    // ----------------------------------------------------------------
    // Interrupt events
    // ----------------------------------------------------------------
    logic [fcc_pkg::IRQ_W-1:0] irq_set_w, irq_clr_w, irq_stat_q, irq_mask_q;
    logic running_w;

    assign running_w = (state_q == fcc_pkg::FCC_ON) || (state_q == fcc_pkg::FCC_OFF);
    always_comb begin
        irq_set_w = '0;
        irq_set_w[fcc_pkg::IRQ_DONE] = (state_q == fcc_pkg::FCC_OFF) && (state_d == fcc_pkg::FCC_DONE);
        irq_set_w[fcc_pkg::IRQ_START] = start_w;
        irq_set_w[fcc_pkg::IRQ_ABORT] = running_w && (state_d == fcc_pkg::FCC_IDLE);
        irq_set_w[fcc_pkg::IRQ_BLOCKED] = req_rise_w && !start_w;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_stat_q <= fcc_pkg::IRQ_RESET;
        end else begin
            irq_stat_q <= (irq_stat_q & ~irq_clr_w) | irq_set_w;
        end
    end

    assign irq_o = |(irq_stat_q & irq_mask_q);

    // ----------------------------------------------------------------
    // Wishbone register slave
    // ----------------------------------------------------------------
    logic wr_w, rd_w;
    logic [31:0] status_w, rdata_w;

    assign wr_w = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_sel_i[0];
    assign rd_w = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i;
    assign irq_clr_w = (wr_w && wb_adr_i == fcc_pkg::REG_IRQ_STAT) ? wb_dat_i[fcc_pkg::IRQ_W-1:0] : '0;

    always_comb begin
        status_w = '0;
        status_w[fcc_pkg::ST_RUNNING] = running_w;
        status_w[fcc_pkg::ST_FAST] = fast_q;
        status_w[fcc_pkg::ST_DONE] = (state_q == fcc_pkg::FCC_DONE);
        status_w[fcc_pkg::ST_SUPPLY] = supply_s;
        status_w[fcc_pkg::ST_LIM_LSB +: 2] = peak_current_limit_o;
        status_w[fcc_pkg::ST_SWITCH] = switch_on_o;
        unique case (wb_adr_i)
            fcc_pkg::REG_CTRL: rdata_w = {31'h0, enable_q};
            fcc_pkg::REG_STATUS: rdata_w = status_w;
            fcc_pkg::REG_IRQ_STAT: rdata_w = {28'h0, irq_stat_q};
            fcc_pkg::REG_IRQ_MASK: rdata_w = {28'h0, irq_mask_q};
            default: rdata_w = 32'h0;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            enable_q <= fcc_pkg::CTRL_RESET[fcc_pkg::CTRL_ENABLE];
            irq_mask_q <= fcc_pkg::IRQ_RESET;
        end else if (wr_w) begin
            if (wb_adr_i == fcc_pkg::REG_CTRL) begin
                enable_q <= wb_dat_i[fcc_pkg::CTRL_ENABLE];
            end
            if (wb_adr_i == fcc_pkg::REG_IRQ_MASK) begin
                irq_mask_q <= wb_dat_i[fcc_pkg::IRQ_W-1:0];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
        end else begin
            wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
            wb_dat_o <= rd_w ? rdata_w : 32'h0;
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    logic [7:0] off_len_q;
    always_ff @(posedge clk_i) begin
        if (rst_i || state_q != fcc_pkg::FCC_OFF) begin
            off_len_q <= 8'h00;
        end else begin
            off_len_q <= off_len_q + 8'h01;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_start_qualified: assert property ( // [R1]
        state_q == fcc_pkg::FCC_IDLE ##1 state_q == fcc_pkg::FCC_ON |-> $past(req_rise_w) && $past(supply_s))
        else $error("run started without a qualified rising request");
    a_stale_request: assert property ( // [R2]
        state_q == fcc_pkg::FCC_IDLE && charge_req_i && req_prev_q |=> state_q != fcc_pkg::FCC_ON)
        else $error("run started from a request that was already high");
    a_limit_off: assert property ( // [R3]
        state_q == fcc_pkg::FCC_ON && current_limit_strap_s |=> !switch_on_o && state_q != fcc_pkg::FCC_ON)
        else $error("switch stayed on after current limit");
    a_sense_off: assert property ( // [R4]
        $rose(done_oe_o) |-> $past(!switch_on_o, 2) && $past(fb_s))
        else $error("feedback taken while switch on");
    a_done_hold: assert property ( // [R5]
        state_q == fcc_pkg::FCC_DONE && !req_rise_w |=> !switch_on_o)
        else $error("switch restarted after target without a new request");
    a_fast_on: assert property ( // [R6]
        state_q == fcc_pkg::FCC_OFF && blank_ok_w && swlow_s && !fb_s && charge_req_i && supply_s
        |=> switch_on_o ##1 fast_q)
        else $error("switch node low did not restart the switch");
    a_off_limit: assert property ( // [R7]
        state_q == fcc_pkg::FCC_OFF |-> off_len_q < 8'(fcc_pkg::OFF_MAX_CYC))
        else $error("off interval exceeded its maximum");
    a_mode_handover: assert property ( // [R8]
        $rose(fast_q) |-> $past(swlow_s) && $past(state_q == fcc_pkg::FCC_OFF))
        else $error("fast mode entered without switch node low");
    a_limit_apply: assert property ( // [R10]
        $rose(switch_on_o) |-> peak_current_limit_o == $past(lim_w))
        else $error("cycle started with a stale current limit");
    a_done_drive: assert property ( // [R11]
        state_q == fcc_pkg::FCC_DONE |-> done_oe_o && !done_n_o)
        else $error("completion indicator not driven");
    a_request_low: assert property ( // [R12]
        !charge_req_i |=> !switch_on_o && state_q == fcc_pkg::FCC_IDLE)
        else $error("charging continued with request low");
    // Own disable so the reset itself is the antecedent rather than switching the check off
    a_reset_quiet: assert property (@(posedge clk_i) disable iff (1'b0) rst_i |=> !switch_on_o && !done_oe_o) // [R14]
        else $error("outputs active after reset");

    c_run_done: cover property (state_q == fcc_pkg::FCC_OFF ##1 state_q == fcc_pkg::FCC_DONE);
    c_fast_mode: cover property ($rose(fast_q));
    c_timer_cycle: cover property (state_q == fcc_pkg::FCC_OFF && off_exp_w);
    c_abort: cover property (irq_set_w[fcc_pkg::IRQ_ABORT]);

endmodule : fcc_charger

// *** design/fcc_pkg.sv ***
// Constants, register map and types of the flyback charge controller.
// Assumes a single 10 MHz clock; every timing count derives from CLK_PERIOD_NS.
package fcc_pkg;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 100;
    localparam int OFF_MAX_US = 18;
    localparam int ON_MAX_US = 18;
    localparam int MIN_OFF_NS = 300;
    localparam int CYC_PER_US = 1000 / CLK_PERIOD_NS;
    localparam int MIN_OFF_CYC = (MIN_OFF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int OFF_MAX_CYC = OFF_MAX_US * CYC_PER_US;

    // ----------------------------------------------------------------
    // Strap states and peak current limit codes
    // ----------------------------------------------------------------
    localparam logic [1:0] STRAP_GND = 2'h0;
    localparam logic [1:0] STRAP_FLOAT = 2'h1;
    localparam logic [1:0] STRAP_SUPPLY = 2'h2;
    localparam logic [1:0] LIM_1A0 = 2'h0;
    localparam logic [1:0] LIM_1A2 = 2'h1;
    localparam logic [1:0] LIM_1A4 = 2'h2;

    // ----------------------------------------------------------------
    // Register map (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_IRQ_STAT = 8'h08;
    localparam logic [7:0] REG_IRQ_MASK = 8'h0c;
    localparam int CTRL_ENABLE = 0;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
    localparam int ST_RUNNING = 0;
    localparam int ST_FAST = 1;
    localparam int ST_DONE = 2;
    localparam int ST_SUPPLY = 3;
    localparam int ST_LIM_LSB = 4;
    localparam int ST_SWITCH = 6;
    localparam int IRQ_W = 4;
    localparam int IRQ_DONE = 0;
    localparam int IRQ_START = 1;
    localparam int IRQ_ABORT = 2;
    localparam int IRQ_BLOCKED = 3;
    localparam logic [IRQ_W-1:0] IRQ_RESET = 4'h0;

    typedef enum logic [1:0] {FCC_IDLE, FCC_ON, FCC_OFF, FCC_DONE} fcc_state_t;

endpackage : fcc_pkg

// *** design/fcc_sync.sv ***
// Two-stage synchroniser for a group of asynchronous comparator levels.
// Assumes the outputs are only read in the clk_i domain.
module fcc_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Levels
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] meta_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_q <= '0;
            q_o <= '0;
        end else begin
            meta_q <= d_i;
            q_o <= meta_q;
        end
    end

endmodule : fcc_sync

// *** design/fcc_tick.sv ***
// Restartable divider giving a one-cycle enable pulse every DIV clocks.
// Assumes clr_i restarts the period so the first pulse is DIV cycles later.
module fcc_tick #(
    parameter int DIV = 10
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Control
    input wire logic clr_i,
    output logic tick_o
);
    logic [7:0] cnt_q;

    // The pulse is taken from the count alone, so clr_i never feeds back into it
    assign tick_o = (cnt_q == 8'(DIV - 1));

    always_ff @(posedge clk_i) begin
        if (rst_i || clr_i || tick_o) begin
            cnt_q <= 8'h00;
        end else begin
            cnt_q <= cnt_q + 8'h01;
        end
    end

endmodule : fcc_tick

// *** tb/fcc_analog_model.sv ***
// Behavioural power stage: primary current ramp, flyback ringing and output divider.
// Assumes the bench sets the knobs; the levels feed the charger's comparator inputs.
module fcc_analog_model (
    // Clock and power stage
    input wire logic clk_i,
    input wire logic switch_on_i,
    input wire logic charge_req_i,
    // Scenario knobs
    input wire logic fast_i,
    input wire logic [7:0] hit_dly_i,
    input wire logic [7:0] target_i,
    // Comparator levels
    output logic hit_o,
    output logic node_low_o,
    output logic fb_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] on_q = 8'h00;
    logic [7:0] off_q = 8'h00;
    logic [7:0] pulses_q = 8'h00;
    logic sw_q = 1'b0;

    always_ff @(posedge clk_i) begin
        sw_q <= switch_on_i;
        on_q <= switch_on_i ? on_q + 8'h01 : 8'h00;
        off_q <= (switch_on_i || off_q == 8'hff) ? (switch_on_i ? 8'h00 : off_q) : off_q + 8'h01;
        if (!charge_req_i) begin
            pulses_q <= 8'h00;
        end else if (switch_on_i && !sw_q) begin
            pulses_q <= pulses_q + 8'h01;
        end
    end

    assign hit_o = switch_on_i && on_q >= hit_dly_i;
    assign node_low_o = fast_i && !switch_on_i && off_q >= 8'h04;
    assign fb_o = !switch_on_i && pulses_q >= target_i;
endmodule : fcc_analog_model

// *** tb/fcc_charger_test.sv ***
// Self-checking bench for the flyback charge controller.
// Assumes the analog model on the comparators and Wishbone register access.
module fcc_charger_test;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {logic [1:0] strap; logic [1:0] lim;} fcc_row_t;
    localparam fcc_row_t ROWS [4] = '{'{2'h0, 2'h0}, '{2'h1, 2'h1}, '{2'h2, 2'h2}, '{2'h3, 2'h1}};
    logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic req = 1'b1, sup = 1'b1, fast = 1'b0;
    logic [7:0] adr = 8'h00, target = 8'hff;
    logic [3:0] sel = 4'hf;
    logic [31:0] dat = 32'h0, dat_o, q;
    logic [1:0] strap = 2'h0, lim;
    logic ack, hit, nlow, fb, sw, done_n, done_oe, irq;
    int n_mismatch = 0, n_tests = 0, on_len, off_len, t;

    fcc_charger uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
        .charge_req_i(req), .current_limit_strap_i(strap), .current_limit_hit_i(hit),
        .switch_node_low_i(nlow), .voltage_sense_input_i(fb), .supply_lockout_ok_i(sup),
        .switch_on_o(sw), .peak_current_limit_o(lim), .done_n_o(done_n), .done_oe_o(done_oe), .irq_o(irq));
    fcc_analog_model pm (.clk_i(clk_i), .switch_on_i(sw), .charge_req_i(req), .fast_i(fast),
        .hit_dly_i(8'h05), .target_i(target), .hit_o(hit), .node_low_o(nlow), .fb_o(fb));

    initial begin
        forever #50 clk_i = ~clk_i;
    end

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        n_tests++;
        if (s !== e) begin
            n_mismatch++;
            $display("BAD %s exp %h got %h", nm, e, s);
        end
    endtask : chk

    task automatic final_report;
        $display("checks %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : final_report

    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        do begin
            @(posedge clk_i);
        end while (ack !== 1'b1);
        q = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_i);
        chk("wb ack drop", 0, ack);
    endtask : wb

    task automatic ticks(input int n);
        repeat (n) @(posedge clk_i);
    endtask : ticks

    task automatic wait_sw(input logic v);
        t = 0;
        while (sw !== v && t < 1000) begin
            @(posedge clk_i);
            t++;
        end
    endtask : wait_sw

    task automatic start;
        req <= 1'b0;
        ticks(2);
        req <= 1'b1;
        ticks(1);
    endtask : start

    // Length of the next on interval and of the off interval after it
    task automatic measure;
        wait_sw(1'b1);
        on_len = 0;
        while (sw === 1'b1 && on_len < 400) begin
            @(posedge clk_i);
            on_len++;
        end
        off_len = 0;
        while (sw !== 1'b1 && off_len < 400) begin
            @(posedge clk_i);
            off_len++;
        end
    endtask : measure

    initial begin
        ticks(30000);
        n_mismatch++;
        final_report();
    end

    initial begin
        ticks(6);
        rst_i <= 1'b0;
        ticks(21);
        chk("no run at release", 0, sw);
        chk("limit at reset", 1, lim);
        foreach (ROWS[i]) begin
            strap <= ROWS[i].strap;
            start();
            wait_sw(1'b1);
            chk("limit code", ROWS[i].lim, lim);
        end
        strap <= 2'h0;
        start();
        measure();
        chk("on time", 1, on_len >= 5 && on_len <= 10);
        chk("timer off", 1, off_len >= fcc_pkg::OFF_MAX_CYC - 2 && off_len <= fcc_pkg::OFF_MAX_CYC + 2);
        wb(1'b0, fcc_pkg::REG_STATUS, 32'h0);
        chk("timer flag", 0, q[fcc_pkg::ST_FAST]);
        fast <= 1'b1;
        strap <= 2'h2;
        measure();
        measure();
        chk("fast off", 1, off_len < 20);
        chk("new limit", fcc_pkg::LIM_1A4, lim);
        wb(1'b0, fcc_pkg::REG_STATUS, 32'h0);
        chk("fast flag", 1, q[fcc_pkg::ST_FAST]);
        req <= 1'b0;
        ticks(3);
        chk("abort", 0, sw);
        wb(1'b0, fcc_pkg::REG_IRQ_STAT, 32'h0);
        chk("abort irq", 1, q[fcc_pkg::IRQ_ABORT]);
        wb(1'b1, fcc_pkg::REG_IRQ_STAT, 32'hf);
        target <= 8'h03;
        start();
        t = 0;
        while (done_oe !== 1'b1 && t < 3000) begin
            @(posedge clk_i);
            t++;
        end
        chk("done", 1, done_oe);
        chk("done level", 0, done_n);
        ticks(30);
        chk("stays idle", 0, sw);
        chk("irq masked", 0, irq);
        wb(1'b1, fcc_pkg::REG_IRQ_MASK, 32'hf);
        chk("irq", 1, irq);
        wb(1'b0, fcc_pkg::REG_IRQ_STAT, 32'h0);
        chk("irq stat", 32'h3, q);
        wb(1'b1, fcc_pkg::REG_IRQ_STAT, 32'h3);
        chk("irq clear", 0, irq);
        req <= 1'b0;
        ticks(3);
        chk("done release", 0, done_oe);
        sup <= 1'b0;
        ticks(4);
        req <= 1'b1;
        ticks(10);
        chk("lockout", 0, sw);
        sup <= 1'b1;
        ticks(20);
        chk("held high", 0, sw);
        wb(1'b0, fcc_pkg::REG_IRQ_STAT, 32'h0);
        chk("blocked", 1, q[fcc_pkg::IRQ_BLOCKED]);
        wb(1'b1, fcc_pkg::REG_CTRL, 32'h0);
        start();
        ticks(10);
        chk("disabled", 0, sw);
        wb(1'b1, fcc_pkg::REG_CTRL, 32'h1);
        target <= 8'hff;
        start();
        wait_sw(1'b1);
        chk("fresh rise", 1, sw);
        wb(1'b1, 8'h10, 32'hf);
        wb(1'b0, 8'h10, 32'h0);
        chk("unmapped", 0, q);
        rst_i <= 1'b1;
        ticks(3);
        chk("reset switch", 0, sw);
        chk("reset irq", 0, irq);
        rst_i <= 1'b0;
        ticks(3);
        wb(1'b0, fcc_pkg::REG_CTRL, 32'h0);
        chk("ctrl reset", fcc_pkg::CTRL_RESET, q);
        wb(1'b0, fcc_pkg::REG_IRQ_MASK, 32'h0);
        chk("mask reset", 0, q);
        ticks(10);
        chk("idle after reset", 0, sw);
        final_report();
    end
endmodule : fcc_charger_test
